// ===== hdl/pbm_pin_cell.sv
// one pad driver: picks gpio or peripheral and registers pad signals
// assumes all select inputs are on system_clock_main
`timescale 1ns/1ps
module pbm_pin_cell (
  input  wire logic system_clock_main,
  input  wire logic rst,
  input  wire logic periph_sel,
  input  wire logic gpio_val,
  input  wire logic gpio_dir,
  input  wire logic alt_val,
  input  wire logic alt_drive,
  output logic      pad_out,
  output logic      pad_oe_n
);

  logic out_reg;
  logic out_next;
  logic oe_n_reg;
  logic oe_n_next;

  // peripheral owns the pad when selected, else gpio data/direction
  always_comb begin
    if (periph_sel) begin
      out_next  = alt_val;
      oe_n_next = ~alt_drive;
    end else begin
      out_next  = gpio_val;
      oe_n_next = ~gpio_dir;
    end
  end

  // pad released in reset
  always_ff @(posedge system_clock_main or posedge rst) begin
    if (rst) begin
      out_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      out_reg  <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign pad_out  = out_reg;
  assign pad_oe_n = oe_n_reg;

endmodule

// ===== hdl/pbm_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs may change at any time relative to system_clock_main
`timescale 1ns/1ps
module pbm_sync #(
  parameter int W = 1
) (
  input  wire logic         system_clock_main,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // a bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  // shift chain; first stage feeds only the second
  always_ff @(posedge system_clock_main or posedge rst) begin
    if (rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

// ===== hdl/pbm_top.sv
// pin multiplexer for port b pins 4..7 and port f pins 9..15
// assumes one system_clock_main domain, a word register port with read data one
// cycle after the strobe, and an external memory interface on system_clock_main
//
// Contract
// - each upper port b pin is software gpio input or output
// - after reset upper port b pins are gpio
// - clock monitor order: prescaler, system, second system, oscillator
// - address function drives address lines 20 to 23
// - per-pin peripheral enable takes gpio away from a port b pin
// - clock select chooses address or clock monitor per released pin
// - idle drive bit decides address pins tri-state when bus idle
// - data function carries data bits 0 to 6 both ways
// - idle drive bit decides data pins tri-state when bus idle
// - port f pins 9 to 15 are individually gpio in or out
// - after reset port f pins serve the data bus
// - clearing a port f pull-up bit turns that pull-up off
`timescale 1ns/1ps
module pbm_top
  import pbm_pkg::*;
(
  input  wire logic                system_clock_main,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  input  wire pbm_emi_req_t        emi_req,
  output logic      [PF_W-1:0]     emi_rdata,
  input  wire logic                prescaler_clk,
  input  wire logic                system_clock_second,
  input  wire logic                osc_clk,
  input  wire logic [PB_W-1:0]     pb_pin_in,
  output pbm_pb_pad_t              pb_pin,
  output logic      [PB_W-1:0]     pb_pullup_en,
  input  wire logic [PF_W-1:0]     pf_pin_in,
  output pbm_pf_pad_t              pf_pin,
  output logic      [PF_W-1:0]     pf_pullup_en
);

  // ********************************
  // register state
  // ********************************
  logic [PB_W-1:0]   pb_data_reg;
  logic [PB_W-1:0]   pb_data_next;
  logic [PB_W-1:0]   pb_ddr_reg;
  logic [PB_W-1:0]   pb_ddr_next;
  logic [PB_W-1:0]   pb_per_reg;
  logic [PB_W-1:0]   pb_per_next;
  logic [PB_W-1:0]   pb_pur_reg;
  logic [PB_W-1:0]   pb_pur_next;
  logic [PF_W-1:0]   pf_data_reg;
  logic [PF_W-1:0]   pf_data_next;
  logic [PF_W-1:0]   pf_ddr_reg;
  logic [PF_W-1:0]   pf_ddr_next;
  logic [PF_W-1:0]   pf_per_reg;
  logic [PF_W-1:0]   pf_per_next;
  logic [PF_W-1:0]   port_f_pullup_reg;
  logic [PF_W-1:0]   port_f_pullup_next;
  logic [PB_W-1:0]   clock_out_select_reg;
  logic [PB_W-1:0]   clock_out_select_next;
  logic              bus_idle_drive_bit_reg;
  logic              bus_idle_drive_bit_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // ********************************
  // synchronised pins and clocks
  // ********************************
  logic [PB_W-1:0]   pb_in_sync;
  logic [PF_W-1:0]   pf_in_sync;
  logic [2:0]        mon_sync;
  logic              main_mon_reg;
  logic              main_mon_next;
  logic [PF_W-1:0]   emi_rdata_reg;
  logic [PF_W-1:0]   emi_rdata_next;
  logic [PB_W-1:0]   pb_pull_reg;
  logic [PB_W-1:0]   pb_pull_next;
  logic [PF_W-1:0]   pf_pull_reg;
  logic [PF_W-1:0]   pf_pull_next;

  // ********************************
  // pad side signals for each cell
  // ********************************
  logic [PB_W-1:0]   pb_alt_val;
  logic [PB_W-1:0]   pb_alt_drive;
  logic [PB_W-1:0]   pb_mon_val;
  logic [PF_W-1:0]   pf_alt_drive;
  logic              idle_drive;

  // ********************************
  // input synchronisers
  // ********************************

  // upper port b pad levels for gpio reads
  pbm_sync #(.W(PB_W)) u_pb_sync (
    .system_clock_main  (system_clock_main),
    .rst      (rst),
    .async_in (pb_pin_in),
    .sync_out (pb_in_sync)
  );

  // port f pad levels serve gpio reads and data bus reads
  pbm_sync #(.W(PF_W)) u_pf_sync (
    .system_clock_main  (system_clock_main),
    .rst      (rst),
    .async_in (pf_pin_in),
    .sync_out (pf_in_sync)
  );

  // monitored clocks from other domains: prescaler, second, oscillator
  pbm_sync #(.W(3)) u_mon_sync (
    .system_clock_main  (system_clock_main),
    .rst      (rst),
    .async_in ({osc_clk, system_clock_second, prescaler_clk}),
    .sync_out (mon_sync)
  );

  // ********************************
  // register next values
  // ********************************

  // software writes fields; reads capture state for next cycle
  always_comb begin
    pb_data_next            = pb_data_reg;
    pb_ddr_next             = pb_ddr_reg;
    pb_per_next             = pb_per_reg;
    pb_pur_next             = pb_pur_reg;
    pf_data_next            = pf_data_reg;
    pf_ddr_next             = pf_ddr_reg;
    pf_per_next             = pf_per_reg;
    port_f_pullup_next      = port_f_pullup_reg;
    clock_out_select_next   = clock_out_select_reg;
    bus_idle_drive_bit_next = bus_idle_drive_bit_reg;
    rdata_next              = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_PB_DATA: pb_data_next = reg_wdata[PB_LSB +: PB_W];
        OFS_PB_DDR:  pb_ddr_next  = reg_wdata[PB_LSB +: PB_W];
        OFS_PB_PER:  pb_per_next  = reg_wdata[PB_LSB +: PB_W];
        OFS_PB_PUR:  pb_pur_next  = reg_wdata[PB_LSB +: PB_W];
        OFS_PF_DATA: pf_data_next = reg_wdata[PF_LSB +: PF_W];
        OFS_PF_DDR:  pf_ddr_next  = reg_wdata[PF_LSB +: PF_W];
        OFS_PF_PER:  pf_per_next  = reg_wdata[PF_LSB +: PF_W];
        OFS_PF_PUR: begin
          port_f_pullup_next = reg_wdata[PF_LSB +: PF_W];
        end
        OFS_CLOCK_OUT_SELECT_REG: begin
          clock_out_select_next = reg_wdata[CKS_LSB +: PB_W];
        end
        OFS_BCR: begin
          bus_idle_drive_bit_next = reg_wdata[DRV_POS];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_PB_DATA: rdata_next[PB_LSB +: PB_W] = pb_data_reg;
        OFS_PB_DDR:  rdata_next[PB_LSB +: PB_W] = pb_ddr_reg;
        OFS_PB_PER:  rdata_next[PB_LSB +: PB_W] = pb_per_reg;
        OFS_PB_PUR:  rdata_next[PB_LSB +: PB_W] = pb_pur_reg;
        OFS_PB_PIN:  rdata_next[PB_LSB +: PB_W] = pb_in_sync;
        OFS_PF_DATA: rdata_next[PF_LSB +: PF_W] = pf_data_reg;
        OFS_PF_DDR:  rdata_next[PF_LSB +: PF_W] = pf_ddr_reg;
        OFS_PF_PER:  rdata_next[PF_LSB +: PF_W] = pf_per_reg;
        OFS_PF_PUR:  rdata_next[PF_LSB +: PF_W] = port_f_pullup_reg;
        OFS_PF_PIN:  rdata_next[PF_LSB +: PF_W] = pf_in_sync;
        OFS_CLOCK_OUT_SELECT_REG: begin
          rdata_next[CKS_LSB +: PB_W] = clock_out_select_reg;
        end
        OFS_BCR:     rdata_next[DRV_POS] = bus_idle_drive_bit_reg;
        default:     rdata_next = '0;  // unmapped reads as zero
      endcase
    end
  end

  // register file storage; reset puts both groups in documented state
  always_ff @(posedge system_clock_main or posedge rst) begin
    if (rst) begin
      pb_data_reg            <= PB_DATA_RST;
      pb_ddr_reg             <= PB_DDR_RST;
      pb_per_reg             <= PB_PER_RST;
      pb_pur_reg             <= PB_PUR_RST;
      pf_data_reg            <= PF_DATA_RST;
      pf_ddr_reg             <= PF_DDR_RST;
      pf_per_reg             <= PF_PER_RST;
      port_f_pullup_reg      <= PF_PUR_RST;
      clock_out_select_reg   <= CLOCK_OUT_SELECT_REG_RST;
      bus_idle_drive_bit_reg <= DRV_RST;
      rdata_reg              <= '0;
    end else begin
      pb_data_reg            <= pb_data_next;
      pb_ddr_reg             <= pb_ddr_next;
      pb_per_reg             <= pb_per_next;
      pb_pur_reg             <= pb_pur_next;
      pf_data_reg            <= pf_data_next;
      pf_ddr_reg             <= pf_ddr_next;
      pf_per_reg             <= pf_per_next;
      port_f_pullup_reg      <= port_f_pullup_next;
      clock_out_select_reg   <= clock_out_select_next;
      bus_idle_drive_bit_reg <= bus_idle_drive_bit_next;
      rdata_reg              <= rdata_next;
    end
  end

  // ********************************
  // peripheral function selection
  // ********************************

  // idle cycles drive only when the drive bit is set
  assign idle_drive = ~emi_req.active & bus_idle_drive_bit_reg;

  // monitor order on pins 4..7: prescaler, main, second, oscillator
  assign pb_mon_val = {mon_sync[2], mon_sync[1],
                       main_mon_reg, mon_sync[0]};

  // port b alternate value and drive: clock monitor or address line
  always_comb begin
    for (int i = 0; i < PB_W; i++) begin
      if (clock_out_select_reg[i]) begin
        pb_alt_val[i]   = pb_mon_val[i];
        pb_alt_drive[i] = 1'b1;
      end else begin
        pb_alt_val[i]   = emi_req.addr_hi[i];
        pb_alt_drive[i] = emi_req.active | idle_drive;
      end
    end
  end

  // data pins drive on write cycles and, if enabled, when idle
  assign pf_alt_drive = {PF_W{(emi_req.active & emi_req.write)
                              | idle_drive}};

  // ********************************
  // pad cells
  // ********************************
  genvar g;

  // port b cells: peripheral enable releases gpio
  generate
    for (g = 0; g < PB_W; g++) begin : g_pb
      pbm_pin_cell u_cell (
        .system_clock_main    (system_clock_main),
        .rst        (rst),
        .periph_sel (pb_per_reg[g]),
        .gpio_val   (pb_data_reg[g]),
        .gpio_dir   (pb_ddr_reg[g]),
        .alt_val    (pb_alt_val[g]),
        .alt_drive  (pb_alt_drive[g]),
        .pad_out    (pb_pin.out[g]),
        .pad_oe_n   (pb_pin.oe_n[g])
      );
    end
  endgenerate

  // port f cells: data bus unless peripheral enable cleared
  generate
    for (g = 0; g < PF_W; g++) begin : g_pf
      pbm_pin_cell u_cell (
        .system_clock_main    (system_clock_main),
        .rst        (rst),
        .periph_sel (pf_per_reg[g]),
        .gpio_val   (pf_data_reg[g]),
        .gpio_dir   (pf_ddr_reg[g]),
        .alt_val    (emi_req.wdata[g]),
        .alt_drive  (pf_alt_drive[g]),
        .pad_out    (pf_pin.out[g]),
        .pad_oe_n   (pf_pin.oe_n[g])
      );
    end
  endgenerate

  // ********************************
  // monitor, read data and pull-ups
  // ********************************

  // main clock seen as a half-rate toggle; inbound data bits, pull-ups
  always_comb begin
    main_mon_next  = ~main_mon_reg;
    emi_rdata_next = pf_in_sync;
    pb_pull_next   = pb_pur_reg;
    pf_pull_next   = port_f_pullup_reg;
  end

  // registered copies that leave the block
  always_ff @(posedge system_clock_main or posedge rst) begin
    if (rst) begin
      main_mon_reg  <= 1'b0;
      emi_rdata_reg <= '0;
      pb_pull_reg   <= PB_PUR_RST;
      pf_pull_reg   <= PF_PUR_RST;
    end else begin
      main_mon_reg  <= main_mon_next;
      emi_rdata_reg <= emi_rdata_next;
      pb_pull_reg   <= pb_pull_next;
      pf_pull_reg   <= pf_pull_next;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign emi_rdata    = emi_rdata_reg;
  assign pb_pullup_en = pb_pull_reg;
  assign pf_pullup_en = pf_pull_reg;

endmodule

// ===== inc/pbm_pkg.sv
// package of the port-b high / data pin multiplexer
// assumes one 50 mhz system clock and a 16-bit word register port with 4-bit address
package pbm_pkg;

  // ********************************
  // register port geometry
  // ********************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ********************************
  // register offsets (word index)
  // ********************************
  localparam logic [3:0] OFS_PB_DATA   = 4'h0;
  localparam logic [3:0] OFS_PB_DDR    = 4'h1;
  localparam logic [3:0] OFS_PB_PER    = 4'h2;
  localparam logic [3:0] OFS_PB_PUR    = 4'h3;
  localparam logic [3:0] OFS_PB_PIN    = 4'h4;
  localparam logic [3:0] OFS_PF_DATA   = 4'h5;
  localparam logic [3:0] OFS_PF_DDR    = 4'h6;
  localparam logic [3:0] OFS_PF_PER    = 4'h7;
  localparam logic [3:0] OFS_PF_PUR    = 4'h8;
  localparam logic [3:0] OFS_PF_PIN    = 4'h9;
  localparam logic [3:0] OFS_CLOCK_OUT_SELECT_REG    = 4'ha;
  localparam logic [3:0] OFS_BCR       = 4'hb;

  // ********************************
  // field positions and widths
  // ********************************
  localparam int PB_W     = 4;
  localparam int PF_W     = 7;
  localparam int PB_LSB   = 4;  // port b pins 4..7
  localparam int PF_LSB   = 9;  // port f pins 9..15
  localparam int CKS_LSB  = 0;  // clock select bits 3:0 follow pins 4..7
  localparam int DRV_POS  = 0;  // idle drive bit in bus control

  // ********************************
  // reset values
  // ********************************
  localparam logic [3:0] PB_DATA_RST = 4'h0;
  localparam logic [3:0] PB_DDR_RST  = 4'h0;
  localparam logic [3:0] PB_PER_RST  = 4'h0;
  localparam logic [3:0] PB_PUR_RST  = 4'hf;
  localparam logic [6:0] PF_DATA_RST = 7'h00;
  localparam logic [6:0] PF_DDR_RST  = 7'h00;
  localparam logic [6:0] PF_PER_RST  = 7'h7f;
  localparam logic [6:0] PF_PUR_RST  = 7'h7f;
  localparam logic [3:0] CLOCK_OUT_SELECT_REG_RST  = 4'h0;
  localparam logic       DRV_RST     = 1'b0;

  // ********************************
  // carriers
  // ********************************
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } pbm_pb_pad_t;

  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe_n;
  } pbm_pf_pad_t;

  typedef struct packed {
    logic [3:0] addr_hi;
    logic [6:0] wdata;
    logic       active;
    logic       write;
  } pbm_emi_req_t;

endpackage

// ===== tb/pbm_assertions.sv
// assertions on the pbm_top pads, fed by shadows of its mux registers
// assumes binding to pbm_top and one system_clock_main domain
`timescale 1ns/1ps
module pbm_assertions
  import pbm_pkg::*;
(
  input wire logic              system_clock_main,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire pbm_emi_req_t      emi_req,
  input wire pbm_pb_pad_t       pb_pin,
  input wire pbm_pf_pad_t       pf_pin
);
  // ***
  // shadows
  // ***
  logic [3:0] pd_reg, pdir_reg, pper_reg, psel_reg;
  logic [6:0] fd_reg, fdir_reg, fper_reg;
  logic       drv_reg;
  // follow writes to the mux registers
  always_ff @(posedge system_clock_main or posedge rst) begin
    if (rst) begin
      pd_reg   <= PB_DATA_RST;
      pdir_reg <= PB_DDR_RST;
      pper_reg <= PB_PER_RST;
      psel_reg <= CLOCK_OUT_SELECT_REG_RST;
      fd_reg   <= PF_DATA_RST;
      fdir_reg <= PF_DDR_RST;
      fper_reg <= PF_PER_RST;
      drv_reg  <= DRV_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_PB_DATA: pd_reg <= reg_wdata[7:4];
        OFS_PB_DDR:  pdir_reg <= reg_wdata[7:4];
        OFS_PB_PER:  pper_reg <= reg_wdata[7:4];
        OFS_CLOCK_OUT_SELECT_REG:  psel_reg <= reg_wdata[3:0];
        OFS_PF_DATA: fd_reg <= reg_wdata[15:9];
        OFS_PF_DDR:  fdir_reg <= reg_wdata[15:9];
        OFS_PF_PER:  fper_reg <= reg_wdata[15:9];
        OFS_BCR:     drv_reg <= reg_wdata[0];
        default: ;
      endcase
    end
  end
  // pin groups and bus drive conditions
  wire [3:0] adr  = pper_reg & ~psel_reg;
  wire [3:0] mon  = pper_reg & psel_reg;
  wire       adrv = emi_req.active | drv_reg;
  wire       fdrv = emi_req.active ? emi_req.write : drv_reg;
  // ***
  // properties
  // ***
  default clocking cb @(posedge system_clock_main); endclocking
  default disable iff (rst);
  property p_pb_gpio;
    !$past(rst) |-> ((pb_pin.oe_n ^ ~$past(pdir_reg)) & ~$past(pper_reg))
      == 4'h0 && ((pb_pin.out ^ $past(pd_reg)) & ~$past(pper_reg)) == 4'h0;
  endproperty
  a_pb_gpio: assert property (p_pb_gpio) else $error("pb gpio pad");
  property p_pb_rst;
    $past(rst) |-> pb_pin.oe_n == 4'hf && pb_pin.out == 4'h0;
  endproperty
  a_pb_rst: assert property (p_pb_rst) else $error("pb not gpio");
  property p_pb_mon;
    !$past(rst) |-> (pb_pin.oe_n & $past(mon)) == 4'h0;
  endproperty
  a_pb_mon: assert property (p_pb_mon) else $error("monitor off");
  property p_pb_tog;
    $past(mon[1], 2) && $past(mon[1]) |->
      pb_pin.out[1] != $past(pb_pin.out[1]);
  endproperty
  a_pb_tog: assert property (p_pb_tog) else $error("no toggle");
  property p_pb_addr;
    !$past(rst) |->
      ((pb_pin.out ^ $past(emi_req.addr_hi)) & $past(adr)) == 4'h0;
  endproperty
  a_pb_addr: assert property (p_pb_addr) else $error("addr out");
  property p_pb_idle;
    !$past(rst) |->
      (pb_pin.oe_n & $past(adr)) == ({4{~$past(adrv)}} & $past(adr));
  endproperty
  a_pb_idle: assert property (p_pb_idle) else $error("addr oe");
  property p_pf_data;
    !$past(rst) |->
      ((pf_pin.out ^ $past(emi_req.wdata))
        & $past(fper_reg & {7{fdrv}})) == 7'h0;
  endproperty
  a_pf_data: assert property (p_pf_data) else $error("data out");
  property p_pf_idle;
    !$past(rst) |->
      (pf_pin.oe_n & $past(fper_reg)) == ({7{~$past(fdrv)}} & $past(fper_reg));
  endproperty
  a_pf_idle: assert property (p_pf_idle) else $error("data oe");
  property p_pf_gpio;
    !$past(rst) |-> ((pf_pin.oe_n ^ ~$past(fdir_reg)) & ~$past(fper_reg))
      == 7'h0 && ((pf_pin.out ^ $past(fd_reg)) & ~$past(fper_reg)) == 7'h0;
  endproperty
  a_pf_gpio: assert property (p_pf_gpio) else $error("pf gpio pad");
endmodule

bind pbm_top pbm_assertions chk_u (.system_clock_main, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .emi_req, .pb_pin, .pf_pin);

// ===== tb/pbm_mem_model.sv
// external memory bus: issues bus cycles, drives data pads on reads
// assumes go pulses from the bench; pads resolve design, memory, pull-up
`timescale 1ns/1ps
module pbm_mem_model
  import pbm_pkg::*;
#(
  parameter int LEN = 8
)
(
  input  wire logic        system_clock_main,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        go_wr,
  input  wire logic [3:0]  go_addr,
  input  wire logic [6:0]  go_data,
  input  wire pbm_pf_pad_t pf_pin,
  input  wire logic [6:0]  pf_pullup_en,
  output pbm_emi_req_t     emi_req,
  output logic [6:0]       pf_pin_in,
  output logic             busy
);
  logic [7:0] cnt;
  logic [6:0] mem;
  logic [6:0] last;
  assign busy = emi_req.active;
  // one bus cycle of LEN clocks; released lines show inverted values
  always_ff @(posedge system_clock_main or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      emi_req <= '0;
      mem <= 7'h00;
    end else if (go && !busy) begin
      cnt <= 8'(LEN);
      emi_req <= '{go_addr, go_data, 1'b1, go_wr};
      if (go_wr) mem <= go_data;
    end else if (cnt == 8'h01) begin
      cnt <= 8'h00;
      emi_req <= {~emi_req.addr_hi, ~emi_req.wdata, 2'b00};
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // pad level: design first, then memory on reads, pull-up, else noise
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!pf_pin.oe_n[i]) pf_pin_in[i] = pf_pin.out[i];
      else if (busy && !emi_req.write) pf_pin_in[i] = mem[i];
      else if (pf_pullup_en[i]) pf_pin_in[i] = 1'b1;
      else pf_pin_in[i] = ~last[i];
    end
  end
  // last pad level, to make undriven pins change every cycle
  always_ff @(posedge system_clock_main or posedge rst) begin
    if (rst) last <= 7'h00;
    else last <= pf_pin_in;
  end
endmodule

// ===== tb/pbm_top_bench.sv
// self-checking bench for pbm_top
// assumes pbm_mem_model as far side and pbm_assertions bound to the dut
`timescale 1ns/1ps
module pbm_top_bench
  import pbm_pkg::*;
;
  logic              system_clock_main = 1'b0;
  logic              rst = 1'b1;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              go = 1'b0;
  logic              go_wr = 1'b0;
  logic [3:0]        go_addr = '0;
  logic [6:0]        go_data = '0;
  logic [2:0]        ck = 3'h0;  // prescaler, second, oscillator
  logic [3:0]        pb_ext = 4'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic [6:0]        emi_rdata, pf_pin_in, pf_pullup_en;
  logic [3:0]        pb_pin_in, pb_pullup_en;
  logic              t;
  pbm_emi_req_t      emi_req;
  pbm_pb_pad_t       pb_pin;
  pbm_pf_pad_t       pf_pin;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  // rows: address, reset value, write data, read back
  localparam logic [63:0] ROWS [11] = '{
    64'h0000_0000_ffff_00f0, 64'h0001_0000_00a0_00a0,
    64'h0002_0000_000f_0000, 64'h0003_00f0_0050_0050,
    64'h0005_0000_ffff_fe00, 64'h0006_0000_5400_5400,
    64'h0007_fe00_01ff_0000, 64'h0008_fe00_0000_0000,
    64'h000a_0000_fff5_0005, 64'h000b_0000_0001_0001,
    64'h000c_0000_ffff_0000};
  // port b pads: driven level or the bench's outside driver
  assign pb_pin_in = (pb_pin.out & ~pb_pin.oe_n) | (pb_ext & pb_pin.oe_n);
  pbm_top dut_u (.system_clock_main, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .emi_req, .emi_rdata, .prescaler_clk(ck[0]),
    .system_clock_second(ck[1]), .osc_clk(ck[2]), .pb_pin_in, .pb_pin,
    .pb_pullup_en, .pf_pin_in, .pf_pin, .pf_pullup_en);
  pbm_mem_model #(.LEN(8)) mem_u (.system_clock_main, .rst, .go, .go_wr, .go_addr,
    .go_data, .pf_pin, .pf_pullup_en, .emi_req, .pf_pin_in, .busy());
  // clock and cycle ceiling
  initial forever #10 system_clock_main = ~system_clock_main;
  always @(posedge system_clock_main) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ***
  // tasks
  // ***
  task automatic chk(input string nm, input logic [15:0] got, e);
    samples_checked++;
    if (got !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge system_clock_main);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge system_clock_main);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge system_clock_main);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [6:0] d);
    go <= 1'b1;
    go_wr <= w;
    go_addr <= a;
    go_data <= d;
    @(posedge system_clock_main);
    go <= 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***
  // main sequence
  // ***
  initial begin
    repeat (4) @(posedge system_clock_main);
    rst <= 1'b0;
    tick(1);
    foreach (ROWS[i]) begin
      rd(ROWS[i][51:48], ROWS[i][47:32]);
      wr(ROWS[i][51:48], ROWS[i][31:16]);
      rd(ROWS[i][51:48], ROWS[i][15:0]);
    end
    $display("test registers done");
    tick(2);
    chk("pb_oe_n", pb_pin.oe_n, 16'h0005);
    chk("pb_out", pb_pin.out & 4'ha, 16'h000a);
    chk("pf_oe_n", pf_pin.oe_n, 16'h0055);
    chk("pf_out", pf_pin.out & 7'h2a, 16'h002a);
    chk("pb_pu", pb_pullup_en, 16'h0005);
    chk("pf_pu", pf_pullup_en, 16'h0000);
    pb_ext <= 4'h5;
    tick(6);
    rd(OFS_PB_PIN, 16'h00f0);
    pb_ext <= 4'h0;
    wr(OFS_PB_PIN, 16'hffff);
    tick(6);
    rd(OFS_PB_PIN, 16'h00a0);
    $display("test gpio done");
    wr(OFS_PF_PER, 16'hfe00);
    wr(OFS_PB_PER, 16'h00f0);
    ck <= 3'h5;
    bus(1'b1, 4'h9, 7'h2a);
    tick(2);
    chk("pb_addr", pb_pin.out & 4'ha, 16'h0008);
    chk("pb_oe_n", pb_pin.oe_n, 16'h0000);
    chk("pf_out", pf_pin.out, 16'h002a);
    tick(6);
    chk("pb_mon", pb_pin.out & 4'h5, 16'h0001);
    tick(2);
    chk("pb_oe_n", pb_pin.oe_n, 16'h0000);
    chk("pf_oe_n", pf_pin.oe_n, 16'h0000);
    wr(OFS_BCR, 16'h0000);
    tick(2);
    chk("pb_oe_n", pb_pin.oe_n, 16'h000a);
    chk("pf_oe_n", pf_pin.oe_n, 16'h007f);
    wr(OFS_CLOCK_OUT_SELECT_REG, 16'h000f);
    tick(6);
    chk("pb_mon", pb_pin.out & 4'hd, 16'h0009);
    chk("pb_oe_n", pb_pin.oe_n, 16'h0000);
    t = pb_pin.out[1];
    tick(1);
    chk("pb_tog", pb_pin.out[1], t ? 16'h0000 : 16'h0001);
    ck <= 3'h2;
    tick(6);
    chk("pb_mon", pb_pin.out & 4'hd, 16'h0004);
    $display("test address and clock done");
    bus(1'b0, 4'h3, 7'h00);
    tick(7);
    chk("pf_oe_n", pf_pin.oe_n, 16'h007f);
    chk("emi_rdata", emi_rdata, 16'h002a);
    $display("test bus read done");
    tick(4);
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(1);
    rd(OFS_PB_PER, 16'h0000);
    rd(OFS_PF_PER, 16'hfe00);
    chk("pb_oe_n", pb_pin.oe_n, 16'h000f);
    chk("pf_pu", pf_pullup_en, 16'h007f);
    $display("test reset done");
    print_verdict();
  end
endmodule
